// >>> adccfg_cfg.svh
// constants for the converter configuration block: offsets, fields, resets
// assumes byte addressing on a 32-bit apb bus, one register per word
`ifndef ADCCFG_CFG_SVH
`define ADCCFG_CFG_SVH
// register byte offsets
`define ADCCFG_OFF_CHAN 8'h00
`define ADCCFG_OFF_SRC 8'h04
`define ADCCFG_OFF_REF 8'h08
`define ADCCFG_OFF_BG 8'h0C
`define ADCCFG_OFF_PIN 8'h10
`define ADCCFG_OFF_STAT 8'h14
// writable bit masks, unimplemented bits are held at zero
`define ADCCFG_MASK_CHAN 32'h0000000F
`define ADCCFG_MASK_SRC 32'h000000F7
`define ADCCFG_MASK_REF 32'h0000009F
`define ADCCFG_MASK_BG 32'h00000001
`define ADCCFG_MASK_PIN 32'h000001FF
// reset values
`define ADCCFG_RST_CHAN 4'h0
`define ADCCFG_RST_SRC 8'h00
`define ADCCFG_RST_REF 8'h00
`define ADCCFG_RST_BG 1'b0
`define ADCCFG_RST_PIN 9'h000
// field positions
`define ADCCFG_SRC_MSB 7
`define ADCCFG_SRC_LSB 4
`define ADCCFG_DIV_MSB 2
`define ADCCFG_DIV_LSB 0
`define ADCCFG_AMP_EN_BIT 7
`define ADCCFG_AMP_IN_BIT 4
`define ADCCFG_REFSEL_MSB 3
`define ADCCFG_REFSEL_LSB 2
`define ADCCFG_GAIN_MSB 1
`define ADCCFG_GAIN_LSB 0
// channel and divider figures
`define ADCCFG_NUM_PINS 9
`define ADCCFG_LAST_CHAN 4'h8
`define ADCCFG_DIV_CNT_W 7
`endif

// >>> adccfg_pkg.sv
// types shared by the converter configuration block
// assumes nothing beyond the constants header
package adccfg_pkg;
  // class of the selected converter input
  typedef enum logic [1:0] {
    ADCCFG_SRC_EXT = 2'b00,
    ADCCFG_SRC_INT = 2'b01,
    ADCCFG_SRC_GND = 2'b10
  } adccfg_src_t;
  // converter reference choice
  typedef enum logic [1:0] {
    ADCCFG_REF_SUPPLY = 2'b00,
    ADCCFG_REF_PIN = 2'b01,
    ADCCFG_REF_AMP = 2'b10
  } adccfg_ref_t;
endpackage

// >>> adccfg_top.sv
// converter configuration: apb registers, input routing, reference, clock divider
// assumes an apb master on i_ref_clk and an analog core taking the one-hot selects
// How it works
// - source 0000, 0100, 11xx route the pin picked by channel_select, codes 0-8.
// - codes 0001-0011 route supply, supply/2, supply/4 to the converter.
// - codes 0101-0111 route amplifier output, its half, its quarter.
// - codes 10xx tie the converter input to ground only.
// - internal sources disconnect every external pin whatever channel_select holds.
// - external source with channel 1001-1111 connects nothing, input floats.
// - bit 3 of the source/clock register reads zero.
// - divider code 000-111 gives conversion enable at clock/1 up to clock/128.
// - gain_amp_enable powers the reference amplifier.
// - bits 6 and 5 of the reference control register read zero.
// - amp_input_select 1 feeds bandgap and drops the amplifier reference pin.
// - reference_select 00 supply, 01 reference pin, 1x amplifier output.
// - internal reference choice disconnects the external reference pin.
// - amp_gain_select passes gain code 00-11 to the amplifier.
// - bandgap_enable turns the bandgap reference on.
// - bits 7 to 1 of bandgap control read zero.
// - analog pin function drops original function and pull-high.
// - analog pin function overrides port direction control.
// - channel_select sits in bits 3-0 of the channel register.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "adccfg_cfg.svh"
module adccfg_top (
  input wire logic i_ref_clk, // system clock, 100 MHz
  input wire logic i_resetn, // async reset, active low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [7:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error, unmapped address
  input wire logic [8:0] i_port_out_en, // port direction, 1 = output
  input wire logic [8:0] i_pull_high_req, // programmed pull-high per pin
  output logic [8:0] o_ext_chan, // one-hot analog pin to converter
  output logic [5:0] o_int_src, // supply,/2,/4,amp,/2,/4
  output logic o_adc_gnd, // converter input tied to ground
  output logic [1:0] o_ref_sel, // converter reference choice
  output logic o_vref_pin_en, // external reference pin connected
  output logic o_amp_en, // reference amplifier powered
  output logic o_amp_from_bandgap, // amplifier fed from bandgap
  output logic o_amp_pin_en, // amplifier reference pin connected
  output logic [1:0] o_amp_gain, // amplifier gain code
  output logic o_bandgap_en, // bandgap reference on
  output logic o_conv_clk_en, // one-cycle conversion clock enable
  output logic [8:0] o_pin_analog, // pin in analog input function
  output logic [8:0] o_port_out_en, // port drive after analog override
  output logic [8:0] o_pull_high_en // pull-high after analog override
);
  import adccfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0] chan_r;
  logic [7:0] src_r;
  logic [7:0] ref_r;
  logic bg_r;
  logic [8:0] pin_r;
  logic [`ADCCFG_DIV_CNT_W-1:0] cnt_r;
  logic [31:0] rd_nxt;
  logic hit_nxt;
  logic wr_go;
  logic [31:0] wd;
  logic [31:0] wchan;
  logic [31:0] wsrc;
  logic [31:0] wref;

  // apb: setup cycle latches answer, access cycle completes with zero wait
  assign wr_go = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;

  // decode and read mux, unimplemented bits come back as zero
  always_comb begin
    rd_nxt = 32'h00000000;
    hit_nxt = 1'b1;
    unique case (i_paddr)
      `ADCCFG_OFF_CHAN: rd_nxt = {28'h0000000, chan_r};
      `ADCCFG_OFF_SRC: rd_nxt = {24'h000000, src_r} & `ADCCFG_MASK_SRC;
      `ADCCFG_OFF_REF: rd_nxt = {24'h000000, ref_r} & `ADCCFG_MASK_REF;
      `ADCCFG_OFF_BG: rd_nxt = {31'h00000000, bg_r};
      `ADCCFG_OFF_PIN: rd_nxt = {23'h000000, pin_r};
      `ADCCFG_OFF_STAT: rd_nxt = {16'h0000, o_adc_gnd, o_int_src, o_ext_chan};
      default: hit_nxt = 1'b0;
    endcase
  end

  // bus answer flops, so the ports come straight from registers
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else if (i_psel && !i_penable) begin
      o_prdata <= i_pwrite ? 32'h00000000 : rd_nxt;
      o_pready <= 1'b1;
      o_pslverr <= !hit_nxt;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // software-written fields; masks keep unimplemented bits at zero
  assign wd = i_pwdata;
  // masks come from the constants so a reserved bit can never be stored
  assign wchan = wd & `ADCCFG_MASK_CHAN;
  assign wsrc = wd & `ADCCFG_MASK_SRC;
  assign wref = wd & `ADCCFG_MASK_REF;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      chan_r <= `ADCCFG_RST_CHAN;
      src_r <= `ADCCFG_RST_SRC;
      ref_r <= `ADCCFG_RST_REF;
      bg_r <= `ADCCFG_RST_BG;
      pin_r <= `ADCCFG_RST_PIN;
    end else if (wr_go) begin
      unique case (i_paddr)
        `ADCCFG_OFF_CHAN: chan_r <= wchan[3:0];
        `ADCCFG_OFF_SRC: src_r <= wsrc[7:0];
        `ADCCFG_OFF_REF: ref_r <= wref[7:0];
        `ADCCFG_OFF_BG: bg_r <= wd[0];
        `ADCCFG_OFF_PIN: pin_r <= wd[8:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input routing
  logic [3:0] sel;
  adccfg_src_t cls;
  logic [8:0] ext_nxt;
  logic [5:0] int_nxt;

  assign sel = src_r[`ADCCFG_SRC_MSB:`ADCCFG_SRC_LSB];

  // classify the source code; one-hot selects never join pin and internal
  always_comb begin
    ext_nxt = 9'h000;
    int_nxt = 6'h00;
    cls = ADCCFG_SRC_EXT;
    unique casez (sel)
      4'b0000, 4'b0100, 4'b11??: cls = ADCCFG_SRC_EXT;
      4'b0001: begin cls = ADCCFG_SRC_INT; int_nxt = 6'h01; end
      4'b0010: begin cls = ADCCFG_SRC_INT; int_nxt = 6'h02; end
      4'b0011: begin cls = ADCCFG_SRC_INT; int_nxt = 6'h04; end
      4'b0101: begin cls = ADCCFG_SRC_INT; int_nxt = 6'h08; end
      4'b0110: begin cls = ADCCFG_SRC_INT; int_nxt = 6'h10; end
      4'b0111: begin cls = ADCCFG_SRC_INT; int_nxt = 6'h20; end
      4'b10??: cls = ADCCFG_SRC_GND;
    endcase
    // only an external class may reach a pin; codes above 8 float
    if (cls == ADCCFG_SRC_EXT && chan_r <= `ADCCFG_LAST_CHAN) begin
      ext_nxt = 9'(9'h001 << chan_r);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ext_chan <= 9'h000;
      o_int_src <= 6'h00;
      o_adc_gnd <= 1'b0;
    end else begin
      o_ext_chan <= ext_nxt;
      o_int_src <= int_nxt;
      o_adc_gnd <= (cls == ADCCFG_SRC_GND);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reference and amplifier
  logic [1:0] rsel;
  adccfg_ref_t ref_nxt;
  assign rsel = ref_r[`ADCCFG_REFSEL_MSB:`ADCCFG_REFSEL_LSB];

  // 1x both mean amplifier output
  always_comb begin
    unique casez (rsel)
      2'b00: ref_nxt = ADCCFG_REF_SUPPLY;
      2'b01: ref_nxt = ADCCFG_REF_PIN;
      default: ref_nxt = ADCCFG_REF_AMP;
    endcase
  end

  // amplifier use is software's job; the block does not force it on
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ref_sel <= 2'b00;
      o_vref_pin_en <= 1'b0;
      o_amp_en <= 1'b0;
      o_amp_from_bandgap <= 1'b0;
      o_amp_pin_en <= 1'b0;
      o_amp_gain <= 2'b00;
      o_bandgap_en <= 1'b0;
    end else begin
      o_ref_sel <= ref_nxt;
      o_vref_pin_en <= (ref_nxt == ADCCFG_REF_PIN);
      o_amp_en <= ref_r[`ADCCFG_AMP_EN_BIT];
      o_amp_from_bandgap <= ref_r[`ADCCFG_AMP_IN_BIT];
      o_amp_pin_en <= !ref_r[`ADCCFG_AMP_IN_BIT];
      o_amp_gain <= ref_r[`ADCCFG_GAIN_MSB:`ADCCFG_GAIN_LSB];
      o_bandgap_en <= bg_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion clock enable
  logic [2:0] div;
  logic [`ADCCFG_DIV_CNT_W-1:0] dmask;
  logic [7:0] dfull;
  assign div = src_r[`ADCCFG_DIV_MSB:`ADCCFG_DIV_LSB];
  // mask of 2^div - 1; a new code takes effect at the next wrap of its bits
  assign dfull = (8'h01 << div) - 8'h01;
  assign dmask = dfull[`ADCCFG_DIV_CNT_W-1:0];

  // free counter, never reset by a code change
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= '0;
      o_conv_clk_en <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      o_conv_clk_en <= (cnt_r & dmask) == dmask;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin function override
  // analog function wins over direction and pull-high settings
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin_analog <= 9'h000;
      o_port_out_en <= 9'h000;
      o_pull_high_en <= 9'h000;
    end else begin
      o_pin_analog <= pin_r;
      o_port_out_en <= i_port_out_en & ~pin_r;
      o_pull_high_en <= i_pull_high_req & ~pin_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_ext_route: assert property (
    (cls == ADCCFG_SRC_EXT && chan_r <= `ADCCFG_LAST_CHAN)
      |=> o_ext_chan == 9'(9'h001 << $past(chan_r)) && o_int_src == 6'h00)
    else $error("external pin not routed");
  a_int_isolate: assert property (
    o_int_src != 6'h00 |-> o_ext_chan == 9'h000 && !o_adc_gnd)
    else $error("pin joined to internal source");
  a_supply_half: assert property (
    sel == 4'b0010 |=> o_int_src == 6'h02)
    else $error("supply half not selected");
  a_amp_quarter: assert property (
    sel == 4'b0111 |=> o_int_src == 6'h20)
    else $error("amplifier quarter not selected");
  a_gnd_tie: assert property (
    sel[3:2] == 2'b10 |=> o_adc_gnd && o_ext_chan == 9'h000 && o_int_src == 6'h00)
    else $error("ground tie missing");
  a_float_chan: assert property (
    cls == ADCCFG_SRC_EXT && chan_r > `ADCCFG_LAST_CHAN |=> o_ext_chan == 9'h000)
    else $error("floating channel connected");
  a_bit3_zero: assert property (
    i_psel && !i_penable && !i_pwrite && i_paddr == `ADCCFG_OFF_SRC |=> o_prdata[3] == 1'b0)
    else $error("reserved bit reads one");
  a_div_period: assert property (
    (div == 3'h2)[*6] ##0 o_conv_clk_en |-> $past(o_conv_clk_en, 4) && !$past(o_conv_clk_en))
    else $error("divide by four period wrong");
  a_ref_pin_off: assert property (
    rsel != 2'b01 |=> !o_vref_pin_en && o_ref_sel == $past(rsel[1] ? 2'b10 : rsel))
    else $error("reference pin left on");
  a_bg_feed: assert property (
    ref_r[`ADCCFG_AMP_IN_BIT] |=> o_amp_from_bandgap && !o_amp_pin_en)
    else $error("amplifier pin not dropped");
  a_pin_override: assert property (
    pin_r != 9'h000 |=> ((o_port_out_en | o_pull_high_en) & $past(pin_r)) == 9'h000)
    else $error("analog pin still driven");

  // every internal code lands on its own one-hot line
  a_supply_full: assert property (
    sel == 4'b0001
      |=> o_int_src == 6'h01 && o_ext_chan == 9'h000)
    else $error("supply not selected");
  a_supply_quarter: assert property (
    sel == 4'b0011
      |=> o_int_src == 6'h04 && o_ext_chan == 9'h000)
    else $error("supply quarter not selected");
  a_amp_full: assert property (
    sel == 4'b0101
      |=> o_int_src == 6'h08 && o_ext_chan == 9'h000)
    else $error("amplifier output not selected");
  a_amp_half: assert property (
    sel == 4'b0110
      |=> o_int_src == 6'h10 && o_ext_chan == 9'h000)
    else $error("amplifier half not selected");
  a_int_no_pin: assert property (
    !sel[3] && sel[1:0] != 2'b00
      |=> o_ext_chan == 9'h000 && !o_adc_gnd)
    else $error("pin left on for internal source");
  a_gnd_only: assert property (
    o_adc_gnd
      |-> o_ext_chan == 9'h000 && o_int_src == 6'h00)
    else $error("ground joined to a signal");

  // reserved bits and the channel field on the read path
  a_ref_rsvd: assert property (
    i_psel && !i_penable && !i_pwrite && i_paddr == `ADCCFG_OFF_REF
      |=> o_prdata[6:5] == 2'b00)
    else $error("reference reserved bits read one");
  a_bg_rsvd: assert property (
    i_psel && !i_penable && !i_pwrite && i_paddr == `ADCCFG_OFF_BG
      |=> o_prdata[7:1] == 7'h00)
    else $error("bandgap reserved bits read one");
  a_chan_read: assert property (
    i_psel && !i_penable && !i_pwrite && i_paddr == `ADCCFG_OFF_CHAN
      |=> o_prdata == {28'h0000000, $past(chan_r)})
    else $error("channel field misread");

  // amplifier, reference and bandgap controls follow their fields
  a_amp_power: assert property (
    1'b1
      |=> o_amp_en == $past(ref_r[`ADCCFG_AMP_EN_BIT]))
    else $error("amplifier power wrong");
  a_pin_feed: assert property (
    !ref_r[`ADCCFG_AMP_IN_BIT]
      |=> o_amp_pin_en && !o_amp_from_bandgap)
    else $error("amplifier pin not connected");
  a_ref_pin_on: assert property (
    rsel == 2'b01
      |=> o_ref_sel == 2'b01 && o_vref_pin_en)
    else $error("reference pin not selected");
  a_ref_amp: assert property (
    rsel[1]
      |=> o_ref_sel == 2'b10 && !o_vref_pin_en)
    else $error("amplifier reference not selected");
  a_gain_pass: assert property (
    1'b1
      |=> o_amp_gain == $past(ref_r[`ADCCFG_GAIN_MSB:`ADCCFG_GAIN_LSB]))
    else $error("gain code wrong");
  a_bg_enable: assert property (
    1'b1
      |=> o_bandgap_en == $past(bg_r))
    else $error("bandgap enable wrong");

  // conversion enable and the free counter; a code change may shorten one period
  a_div_one: assert property (
    div == 3'h0
      |=> o_conv_clk_en)
    else $error("undivided enable missing");
  a_div_seven: assert property (
    (div == 3'h7)[*2] ##0 o_conv_clk_en
      |=> !o_conv_clk_en)
    else $error("divide by 128 pulse too long");
  a_cnt_free: assert property (
    1'b1
      |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("divider counter stalled");

  // pin override keeps the analog pin free of drive and pull-high
  a_pull_drop: assert property (
    pin_r != 9'h000
      |=> (o_pull_high_en & $past(pin_r)) == 9'h000 && o_pin_analog == $past(pin_r))
    else $error("pull-high left on analog pin");
  a_dir_pass: assert property (
    pin_r == 9'h000
      |=> o_port_out_en == $past(i_port_out_en))
    else $error("port direction not passed");
endmodule
`default_nettype wire

// >>> adccfg_core_model.sv
// stand-in for the analog core: counts conversion clock pulses, flags joined inputs
// assumes the selects come straight from the configuration block, same clock
`timescale 1ns/1ps
`default_nettype none
module adccfg_core_model (
  input wire logic i_ref_clk, // system clock
  input wire logic i_resetn, // async reset, active low
  input wire logic i_conv_clk_en, // conversion clock enable
  input wire logic [8:0] i_ext_chan, // external pin select
  input wire logic [5:0] i_int_src, // internal source select
  output logic [15:0] o_pulse_cnt, // conversion pulses seen
  output logic o_joined // external and internal joined
);
  ////////////////////////////////////////////////////////////////
  // pulse counter, the bench diffs it over a fixed window
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn)
      o_pulse_cnt <= 16'h0000;
    else if (i_conv_clk_en)
      o_pulse_cnt <= o_pulse_cnt + 16'h0001;
  end
  // a pin shorted onto an internal node would spoil the sample
  assign o_joined = (|i_ext_chan) && (|i_int_src);
endmodule
`default_nettype wire

// >>> adccfg_top_tb.sv
// self-checking bench for the converter configuration block
// assumes apb slave answers within a few cycles, outputs follow one edge later
`timescale 1ns/1ps
`default_nettype none
module adccfg_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, conv_en, gnd, amp_en, amp_bg, amp_pin, bg_en, vpin, joined;
  logic [8:0] port = 9'h000, pull = 9'h000, ext, pin_an, port_o, pull_o;
  logic [5:0] isrc;
  logic [1:0] rsel, gain;
  logic [15:0] pcnt;
  int err_count = 0, checks = 0;
  ////////////////////////////////////////////////////////////////
  // free-running clock, 10 ns period
  always #5 clk = ~clk;
  adccfg_top u_dut (.i_ref_clk(clk), .i_resetn(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_port_out_en(port), .i_pull_high_req(pull), .o_ext_chan(ext),
    .o_int_src(isrc), .o_adc_gnd(gnd), .o_ref_sel(rsel), .o_vref_pin_en(vpin), .o_amp_en(amp_en),
    .o_amp_from_bandgap(amp_bg), .o_amp_pin_en(amp_pin), .o_amp_gain(gain), .o_bandgap_en(bg_en),
    .o_conv_clk_en(conv_en), .o_pin_analog(pin_an), .o_port_out_en(port_o), .o_pull_high_en(pull_o));
  adccfg_core_model u_core (.i_ref_clk(clk), .i_resetn(rst_n), .i_conv_clk_en(conv_en),
    .i_ext_chan(ext), .i_int_src(isrc), .o_pulse_cnt(pcnt), .o_joined(joined));
  ////////////////////////////////////////////////////////////////
  // verdict, reached from the main sequence or a timed-out wait
  task final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // case equality so an unknown never counts as a match
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // one apb transfer; the bound catches a slave that never answers
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
           output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      final_report();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // outputs land one edge after the write edge
  task wt;
    @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  // reset values, unimplemented bits, bandgap enable
  task t_regs;
    logic [7:0] a;
    logic [31:0] x;
    // bandgap first, so the amplifier never takes it while it is off
    for (int i = 0; i < 3; i++) begin
      a = 8'(12 - 4 * i);
      x = (i == 0) ? 32'h00000001 : (i == 1) ? 32'h0000009F : 32'h000000F7;
      apb(1'b0, a, 32'h0, rd, er);
      chk("reset_val", rd, 32'h0);
      apb(1'b1, a, 32'hFFFFFFFF, rd, er);
      apb(1'b0, a, 32'h0, rd, er);
      chk("rw_mask", rd, x);
    end
    wt();
    chk("bandgap_on", bg_en, 32'h1);
    // amplifier stays on, fed from its pin, before the bandgap goes off
    apb(1'b1, 8'h08, 32'h00000080, rd, er);
    apb(1'b1, 8'h0C, 32'h0, rd, er);
    wt();
    chk("bandgap_off", bg_en, 32'h0);
    $display("register test done");
  endtask
  // every source code against an in-range and an out-of-range channel
  task t_src;
    logic [8:0] xe;
    logic [5:0] xi;
    for (int c = 3; c <= 9; c += 6) begin
      apb(1'b1, 8'h00, 32'(c), rd, er);
      apb(1'b0, 8'h00, 32'h0, rd, er);
      chk("chan_field", rd, 32'(c));
      for (int s = 0; s < 16; s++) begin
        apb(1'b1, 8'h04, 32'(s << 4), rd, er);
        wt();
        xe = ((s == 0 || s == 4 || s >= 12) && c <= 8) ? 9'h001 << c : 9'h000;
        xi = (s inside {[1:3]}) ? 6'h01 << (s - 1) : (s inside {[5:7]}) ? 6'h01 << (s - 2) : 6'h00;
        chk("ext_chan", ext, xe);
        chk("int_src", isrc, xi);
        chk("adc_gnd", gnd, s >= 8 && s < 12);
        chk("joined", joined, 32'h0);
        apb(1'b0, 8'h14, 32'h0, rd, er);
        chk("status", rd, {16'h0000, 1'(s >= 8 && s < 12), xi, xe});
      end
    end
    $display("source test done");
  endtask
  // pulses in a 256-cycle window for each divider code, no reset between
  task t_div;
    logic [15:0] c0;
    for (int d = 0; d < 8; d++) begin
      apb(1'b1, 8'h04, 32'(d), rd, er);
      wt();
      c0 = pcnt;
      repeat (256) @(posedge clk);
      #1;
      chk("conv_pulses", pcnt - c0, 32'(256 >> d));
    end
    $display("divider test done");
  endtask
  // amplifier enable, input, reference choice and gain
  task t_ref;
    logic [3:0] k;
    // bandgap on and settled before any code selects it
    apb(1'b1, 8'h0C, 32'h1, rd, er);
    repeat (16) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      apb(1'b1, 8'h08, {24'h0, k[0] | k[3], 2'b00, k[1], k[3:2], k[1:0]}, rd, er);
      wt();
      chk("amp_en", amp_en, k[0] | k[3]);
      chk("amp_bg", amp_bg, k[1]);
      chk("amp_pin", amp_pin, !k[1]);
      chk("ref_sel", rsel, k[3] ? 2'b10 : {1'b0, k[2]});
      chk("vref_pin", vpin, k[3:2] == 2'b01);
      chk("gain", gain, k[1:0]);
    end
    $display("reference test done");
  endtask
  // analog function drops pull-high and overrides direction
  task t_pin;
    @(posedge clk);
    port <= 9'h1FF;
    pull <= 9'h1FF;
    apb(1'b1, 8'h10, 32'h155, rd, er);
    wt();
    chk("pin_analog", pin_an, 32'h155);
    chk("port_out", port_o, 32'h0AA);
    chk("pull_high", pull_o, 32'h0AA);
    $display("pin test done");
  endtask
  // unmapped address is refused
  task t_bad;
    apb(1'b1, 8'h20, 32'h5, rd, er);
    chk("wr_err", er, 32'h1);
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk("rd_err", er, 32'h1);
    chk("rd_data", rd, 32'h0);
    $display("unmapped test done");
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence: reset 4 cycles, then the scenarios in turn
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_src();
    t_div();
    t_ref();
    t_pin();
    t_bad();
    final_report();
  end
endmodule
`default_nettype wire
